// *** hdl/adcseq_top.v ***
// Converter mode sequencer: serial port, conversion timing, ready flag,
// continuous read and analog front-end enables.
// Assumes a host as serial master (clock idles high, data sampled on the
// rising edge) and a filter that presents a settled sample on raw_sample.
//
// Summary of operation
// - Single mode code powers up, runs exactly one conversion, returns to shutdown.
// - Oscillator gets 1 ms wake time before a conversion started from shutdown.
// - A single conversion lasts two output-rate periods.
// - Ready falls on completion, rises when data word read, stays high after.
// - Outside continuous read the data word can be reread unchanged.
// - After power-up, conversions run continuously with no configuration.
// - Continuous mode clears status ready bit per conversion; pin follows with select.
// - Data read shifts word out on first clocks; ready rises at read end.
// - Command 01011100 streams each new word automatically; host keeps continuous mode.
// - Continuous read: each word read once; ready high until next word.
// - Unfinished continuous read is abandoned and the new word loaded.
// - Continuous read still watches data input; 32 ones reset everything.
// - Buffer bit selects buffering; forced on for gains above 2.
// - Gains 4 and up enable the amplifier; gains 1, 2 are digital.
// - Three-bit gain field picks one of eight gains up to 128.
// - Polarity bit selects unipolar or bipolar range.
// - Unipolar result is straight binary.
// - Bipolar result is offset binary.
// - Word width is 16 or 24 bits per variant.
// - Ready rises before the data register is updated.
`timescale 1ns/1ns
`include "adcseq_map.vh"
module adcseq_top #(
	parameter        DW           = 24,
	parameter [31:0] OSC_WAKE_CYC = `ADCSEQ_OSC_WAKE_US * `ADCSEQ_CLK_MHZ,
	parameter [31:0] TADC_CYC     = `ADCSEQ_TADC_US * `ADCSEQ_CLK_MHZ
) (
	// Clock and reset
	input  wire          core_clk,
	input  wire          sys_rst,
	// Serial pins
	input  wire          sclk,
	input  wire          cs_n,
	input  wire          din,
	output reg           dout,
	output reg           dout_oe,
	// Converter sample
	input  wire [DW-1:0] raw_sample,
	// Front-end controls
	output reg           osc_on,
	output reg           conv_busy,
	output reg           buf_en,
	output reg           inamp_en,
	output reg  [2:0]    gain_select_field,
	output reg           unipolar
);
	// ---------------------------------------------------------------
	// States
	// ---------------------------------------------------------------
	localparam [1:0] S_CMD = 2'h0;
	localparam [1:0] S_WR  = 2'h1;
	localparam [1:0] S_RD  = 2'h2;
	localparam [1:0] C_OFF  = 2'h0;
	localparam [1:0] C_WAKE = 2'h1;
	localparam [1:0] C_CONV = 2'h2;
	localparam [4:0] LEN_REG  = 5'd16;
	localparam [4:0] LEN_STAT = 5'd8;
	localparam [4:0] LEN_DATA = DW[4:0];

	// ---------------------------------------------------------------
	// Pin synchronisers and edges
	// ---------------------------------------------------------------
	wire       sclk_q;
	wire       cs_n_q;
	wire       din_q;
	reg        sclk_d_r;
	reg        ones_rst_r;
	wire       srst = sys_rst | ones_rst_r;

	adcseq_sync #(.W(2), .INIT(1'b1)) u_sync_hi (
		.clk  (core_clk),
		.srst (sys_rst),
		.d    ({sclk, cs_n}),
		.q    ({sclk_q, cs_n_q})
	);

	adcseq_sync #(.W(1), .INIT(1'b0)) u_sync_din (
		.clk  (core_clk),
		.srst (sys_rst),
		.d    (din),
		.q    (din_q)
	);

	wire sel    = ~cs_n_q;
	wire sc_ris = sel & sclk_q & ~sclk_d_r;
	wire sc_fal = sel & ~sclk_q & sclk_d_r;

	// ---------------------------------------------------------------
	// State registers
	// ---------------------------------------------------------------
	reg [1:0]    sst_r;
	reg [4:0]    bitcnt_r;
	reg [4:0]    len_r;
	reg [2:0]    rs_r;
	reg [7:0]    cmd_sh_r;
	reg [15:0]   wr_sh_r;
	reg [DW-1:0] out_sh_r;
	reg          started_r;
	reg [5:0]    ones_r;
	reg          cread_r;
	reg [15:0]   mode_r;
	reg [15:0]   cfg_r;
	reg [DW-1:0] data_r;
	reg          rdy_n_r;
	reg          mode_wr_r;
	reg [1:0]    cst_r;
	reg [31:0]   cnt_r;
	reg          single_r;
	reg          conv_done_r;
	reg          upd_pend_r;
	wire [DW-1:0] code;

	wire [2:0] md   = mode_r[`ADCSEQ_MODE_MD_HI:`ADCSEQ_MODE_MD_LO];
	wire [2:0] gain = cfg_r[`ADCSEQ_CFG_GAIN_HI:`ADCSEQ_CFG_GAIN_LO];
	wire [7:0] cmd_byte = {cmd_sh_r[6:0], din_q};
	wire [7:0] status = {rdy_n_r, 3'h0, (DW == 24) ? 1'b1 : 1'b0, 3'h0};
	wire data_busy = (sst_r == S_RD) && (rs_r == `ADCSEQ_RS_DATA) && !cread_r;

	// ---------------------------------------------------------------
	// Output code former
	// ---------------------------------------------------------------
	adcseq_fmt #(.DW(DW)) u_fmt (
		.clk      (core_clk),
		.srst     (srst),
		.unipolar (cfg_r[`ADCSEQ_CFG_UNI_BIT]),
		.gain_x2  (gain == 3'h1),
		.raw      (raw_sample),
		.code_r   (code)
	);

	// ---------------------------------------------------------------
	// Ones run detector: 32 ones clocked in reset the whole block
	// ---------------------------------------------------------------
	always @(posedge core_clk) begin
		if (srst) begin
			ones_r     <= 6'h00;
			ones_rst_r <= 1'b0;
			sclk_d_r   <= 1'b1;
		end else begin
			sclk_d_r <= sclk_q;
			if (sc_ris) begin
				ones_r <= din_q ? ones_r + 6'h01 : 6'h00;
				ones_rst_r <= din_q && (ones_r == `ADCSEQ_ONES_RESET - 6'h01);
			end
		end
	end

	// ---------------------------------------------------------------
	// Serial engine
	// ---------------------------------------------------------------
	always @(posedge core_clk) begin
		if (srst) begin
			sst_r     <= S_CMD;
			bitcnt_r  <= 5'h00;
			len_r     <= LEN_REG;
			rs_r      <= `ADCSEQ_RS_STATUS;
			cmd_sh_r  <= 8'h00;
			wr_sh_r   <= 16'h0000;
			out_sh_r  <= {DW{1'b0}};
			started_r <= 1'b0;
			cread_r   <= 1'b0;
			mode_r    <= `ADCSEQ_MODE_RST;
			cfg_r     <= `ADCSEQ_CFG_RST;
			mode_wr_r <= 1'b0;
		end else begin
			mode_wr_r <= 1'b0;
			if (cread_r && sc_ris) begin
				cmd_sh_r <= cmd_byte;
				if (cmd_byte == `ADCSEQ_CMD_CREAD_OFF && !rdy_n_r) begin
					cread_r <= 1'b0;
				end
			end
			if (cread_r && upd_pend_r) begin
				out_sh_r  <= code;
				rs_r      <= `ADCSEQ_RS_DATA;
				len_r     <= LEN_DATA;
				bitcnt_r  <= 5'h00;
				started_r <= 1'b0;
				sst_r     <= S_RD;
			end else if (cs_n_q) begin
				bitcnt_r  <= 5'h00;
				started_r <= 1'b0;
				if (!cread_r) begin
					sst_r <= S_CMD;
				end
			end else begin
				case (sst_r)
				S_CMD: begin
					if (sc_ris && !cread_r) begin
						cmd_sh_r <= cmd_byte;
						bitcnt_r <= bitcnt_r + 5'h01;
						if (bitcnt_r == 5'h07) begin
							bitcnt_r  <= 5'h00;
							started_r <= 1'b0;
							rs_r <= cmd_byte[`ADCSEQ_CMD_RS_HI:`ADCSEQ_CMD_RS_LO];
							if (cmd_byte[`ADCSEQ_CMD_WEN_BIT]) begin
								sst_r <= S_CMD;
							end else if (cmd_byte == `ADCSEQ_CMD_CREAD_ON) begin
								cread_r <= 1'b1;
							end else if (cmd_byte[`ADCSEQ_CMD_RD_BIT]) begin
								sst_r <= S_RD;
								case (cmd_byte[`ADCSEQ_CMD_RS_HI:`ADCSEQ_CMD_RS_LO])
								`ADCSEQ_RS_STATUS: begin
									len_r    <= LEN_STAT;
									out_sh_r <= {status, {(DW-8){1'b0}}};
								end
								`ADCSEQ_RS_MODE: begin
									len_r    <= LEN_REG;
									out_sh_r <= {mode_r, {(DW-16){1'b0}}};
								end
								`ADCSEQ_RS_CONFIG: begin
									len_r    <= LEN_REG;
									out_sh_r <= {cfg_r, {(DW-16){1'b0}}};
								end
								`ADCSEQ_RS_DATA: begin
									len_r    <= LEN_DATA;
									out_sh_r <= data_r;
								end
								default: begin
									len_r    <= LEN_STAT;
									out_sh_r <= {DW{1'b0}};
								end
								endcase
							end else if (cmd_byte[`ADCSEQ_CMD_RS_HI:`ADCSEQ_CMD_RS_LO]
								== `ADCSEQ_RS_MODE
								|| cmd_byte[`ADCSEQ_CMD_RS_HI:`ADCSEQ_CMD_RS_LO]
								== `ADCSEQ_RS_CONFIG) begin
								len_r <= LEN_REG;
								sst_r <= S_WR;
							end
						end
					end
				end
				S_WR: begin
					if (sc_ris) begin
						wr_sh_r  <= {wr_sh_r[14:0], din_q};
						bitcnt_r <= bitcnt_r + 5'h01;
						if (bitcnt_r == len_r - 5'h01) begin
							bitcnt_r <= 5'h00;
							sst_r    <= S_CMD;
							if (rs_r == `ADCSEQ_RS_MODE) begin
								mode_r    <= {wr_sh_r[14:0], din_q};
								mode_wr_r <= 1'b1;
							end else begin
								cfg_r <= {wr_sh_r[14:0], din_q};
							end
						end
					end
				end
				S_RD: begin
					if (sc_fal && started_r) begin
						out_sh_r <= {out_sh_r[DW-2:0], 1'b0};
					end
					if (sc_ris) begin
						started_r <= 1'b1;
						bitcnt_r  <= bitcnt_r + 5'h01;
						if (bitcnt_r == len_r - 5'h01) begin
							bitcnt_r <= 5'h00;
							sst_r    <= S_CMD;
						end
					end
				end
				default: begin
					sst_r <= S_CMD;
				end
				endcase
			end
		end
	end

	wire rd_done = sc_ris && (sst_r == S_RD) && (rs_r == `ADCSEQ_RS_DATA)
		&& (bitcnt_r == len_r - 5'h01) && !cs_n_q;

	// ---------------------------------------------------------------
	// Conversion sequencer
	// ---------------------------------------------------------------
	always @(posedge core_clk) begin
		if (srst) begin
			cst_r       <= C_CONV;
			cnt_r       <= 32'h0;
			single_r    <= 1'b0;
			conv_done_r <= 1'b0;
		end else begin
			conv_done_r <= 1'b0;
			if (mode_wr_r) begin
				cnt_r    <= 32'h0;
				single_r <= (md == `ADCSEQ_MD_SINGLE);
				if (md == `ADCSEQ_MD_SINGLE || md == `ADCSEQ_MD_CONT) begin
					cst_r <= (cst_r == C_OFF) ? C_WAKE : C_CONV;
				end else begin
					cst_r <= C_OFF;
				end
			end else begin
				case (cst_r)
				C_OFF: begin
					cnt_r <= 32'h0;
				end
				C_WAKE: begin
					cnt_r <= cnt_r + 32'h1;
					if (cnt_r >= OSC_WAKE_CYC - 32'h1) begin
						cnt_r <= 32'h0;
						cst_r <= C_CONV;
					end
				end
				C_CONV: begin
					cnt_r <= cnt_r + 32'h1;
					if ((single_r && cnt_r >= {TADC_CYC[30:0], 1'b0} - 32'h1)
						|| (!single_r && cnt_r >= TADC_CYC - 32'h1)) begin
						cnt_r       <= 32'h0;
						conv_done_r <= 1'b1;
						if (single_r) begin
							cst_r <= C_OFF;
						end
					end
				end
				default: begin
					cst_r <= C_OFF;
				end
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// Data register and ready flag
	// ---------------------------------------------------------------
	always @(posedge core_clk) begin
		if (srst) begin
			data_r     <= {DW{1'b0}};
			rdy_n_r    <= 1'b1;
			upd_pend_r <= 1'b0;
		end else begin
			upd_pend_r <= 1'b0;
			if (conv_done_r && !data_busy) begin
				rdy_n_r    <= 1'b1;
				upd_pend_r <= 1'b1;
			end else if (upd_pend_r) begin
				data_r  <= code;
				rdy_n_r <= 1'b0;
			end else if (rd_done) begin
				rdy_n_r <= 1'b1;
			end
		end
	end

	// ---------------------------------------------------------------
	// Registered outputs
	// ---------------------------------------------------------------
	always @(posedge core_clk) begin
		if (srst) begin
			dout              <= 1'b1;
			dout_oe           <= 1'b0;
			osc_on            <= 1'b1;
			conv_busy         <= 1'b0;
			buf_en            <= 1'b1;
			inamp_en          <= 1'b1;
			gain_select_field <= 3'h7;
			unipolar          <= 1'b0;
		end else begin
			dout      <= (sst_r == S_RD) ? out_sh_r[DW-1] : rdy_n_r;
			dout_oe   <= sel;
			osc_on    <= (cst_r != C_OFF);
			conv_busy <= (cst_r == C_CONV);
			buf_en    <= cfg_r[`ADCSEQ_CFG_BUF_BIT] | (gain >= `ADCSEQ_GAIN_X4);
			inamp_en  <= (gain >= `ADCSEQ_GAIN_X4);
			gain_select_field <= gain;
			unipolar  <= cfg_r[`ADCSEQ_CFG_UNI_BIT];
		end
	end
endmodule

// *** hdl/adcseq_map.vh ***
// Constants of the converter mode sequencer: codes, field positions,
// reset values and timing figures. Definitions only.
`ifndef ADCSEQ_MAP_VH
`define ADCSEQ_MAP_VH

// ---------------------------------------------------------------
// Clock and timing
// ---------------------------------------------------------------
`define ADCSEQ_CLK_MHZ        250
`define ADCSEQ_OSC_WAKE_US    1000
`define ADCSEQ_TADC_US        16000
`define ADCSEQ_ONES_RESET     6'h20

// ---------------------------------------------------------------
// Register selects (3-bit field of the command byte)
// ---------------------------------------------------------------
`define ADCSEQ_RS_STATUS      3'h0
`define ADCSEQ_RS_MODE        3'h1
`define ADCSEQ_RS_CONFIG      3'h2
`define ADCSEQ_RS_DATA        3'h3

// ---------------------------------------------------------------
// Command byte layout and special commands
// ---------------------------------------------------------------
`define ADCSEQ_CMD_WEN_BIT    7
`define ADCSEQ_CMD_RD_BIT     6
`define ADCSEQ_CMD_RS_HI      5
`define ADCSEQ_CMD_RS_LO      3
`define ADCSEQ_CMD_CREAD_BIT  2
`define ADCSEQ_CMD_CREAD_ON   8'h5c
`define ADCSEQ_CMD_CREAD_OFF  8'h58

// ---------------------------------------------------------------
// Mode register: operating_mode_field in bits 15:13
// ---------------------------------------------------------------
`define ADCSEQ_MODE_MD_HI     15
`define ADCSEQ_MODE_MD_LO     13
`define ADCSEQ_MD_CONT        3'h0
`define ADCSEQ_MD_SINGLE      3'h1
`define ADCSEQ_MODE_RST       16'h000a

// ---------------------------------------------------------------
// Config register: polarity bit 12, gain_select_field 10:8, buffer 4
// ---------------------------------------------------------------
`define ADCSEQ_CFG_UNI_BIT    12
`define ADCSEQ_CFG_GAIN_HI    10
`define ADCSEQ_CFG_GAIN_LO    8
`define ADCSEQ_CFG_BUF_BIT    4
`define ADCSEQ_CFG_RST        16'h0710
`define ADCSEQ_GAIN_X4        3'h2

// ---------------------------------------------------------------
// Status register: ready flag bit 7 (low = word waiting), width bit 3
// ---------------------------------------------------------------
`define ADCSEQ_STAT_RDY_BIT   7
`define ADCSEQ_STAT_W24_BIT   3

`endif

// *** hdl/adcseq_sync.v ***
// Pin input synchroniser: three flops per bit, output follows once
// the second and third flop agree. Inputs are asynchronous to clk.
`timescale 1ns/1ns
module adcseq_sync #(
	parameter W    = 1,
	parameter INIT = 1'b0
) (
	// Clock and reset
	input  wire         clk,
	input  wire         srst,
	// Pins and filtered levels
	input  wire [W-1:0] d,
	output reg  [W-1:0] q
);
	reg [W-1:0] s1_r;
	reg [W-1:0] s2_r;
	reg [W-1:0] s3_r;
	integer i;

	always @(posedge clk) begin
		if (srst) begin
			s1_r <= {W{INIT}};
			s2_r <= {W{INIT}};
			s3_r <= {W{INIT}};
			q    <= {W{INIT}};
		end else begin
			s1_r <= d;
			s2_r <= s1_r;
			s3_r <= s2_r;
			for (i = 0; i < W; i = i + 1) begin
				if (s2_r[i] == s3_r[i]) begin
					q[i] <= s3_r[i];
				end
			end
		end
	end
endmodule

// *** hdl/adcseq_fmt.v ***
// Output code former: digital gain of two, saturation and code format.
// Raw input is unsigned in unipolar, two's complement in bipolar.
`timescale 1ns/1ns
module adcseq_fmt #(
	parameter DW = 24
) (
	// Clock and reset
	input  wire          clk,
	input  wire          srst,
	// Settings
	input  wire          unipolar,
	input  wire          gain_x2,
	// Sample in, formatted code out
	input  wire [DW-1:0] raw,
	output reg  [DW-1:0] code_r
);
	reg [DW-1:0] scaled;

	always @* begin
		scaled = raw;
		if (gain_x2) begin
			if (unipolar) begin
				scaled = raw[DW-1] ? {DW{1'b1}} : {raw[DW-2:0], 1'b0};
			end else if (raw[DW-1] != raw[DW-2]) begin
				scaled = {raw[DW-1], {(DW-1){~raw[DW-1]}}};
			end else begin
				scaled = {raw[DW-2:0], 1'b0};
			end
		end
	end

	always @(posedge clk) begin
		if (srst) begin
			code_r <= {DW{1'b0}};
		end else if (unipolar) begin
			code_r <= scaled;
		end else begin
			code_r <= {~scaled[DW-1], scaled[DW-2:0]};
		end
	end
endmodule

// *** tb/adcseq_checker.sv ***
// Checker: concurrent assertions on the sequencer's top-level ports.
// Assumes one clock domain, bound into adcseq_top below.
`timescale 1ns/1ns
module adcseq_checker #(
	parameter [31:0] TADC_CYC = 32'd4000000
) (
	// Clock and reset
	input wire       core_clk,
	input wire       sys_rst,
	// Pins
	input wire       cs_n,
	input wire       dout_oe,
	// Front-end controls
	input wire       osc_on,
	input wire       conv_busy,
	input wire       buf_en,
	input wire       inamp_en,
	input wire [2:0] gain_select_field
);
	reg [31:0] busy_len_r;
	reg        busy_q_r;

	// Length of the latest conversion run, held after it ends
	always @(posedge core_clk) begin
		busy_q_r <= conv_busy;
		if (sys_rst)
			busy_len_r <= 32'h0;
		else if (conv_busy && !busy_q_r)
			busy_len_r <= 32'h1;
		else if (conv_busy)
			busy_len_r <= busy_len_r + 32'h1;
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	sequence s_deselected;
		cs_n [*8];
	endsequence
	sequence s_waking;
		!conv_busy [*8];
	endsequence

	a_oe_on_select: assert property ($fell(cs_n) |-> ##[1:8] dout_oe)
		else $error("output enable did not follow select");
	a_oe_off_deselect: assert property ($rose(cs_n) |-> ##[1:8] !dout_oe)
		else $error("output enable held after deselect");
	a_oe_idle_off: assert property (s_deselected |-> !dout_oe)
		else $error("pin driven while deselected");
	a_amp_by_gain: assert property ($stable(gain_select_field) |->
		inamp_en == (gain_select_field >= 3'h2)) else $error("amplifier enable wrong for gain");
	a_buf_forced_on: assert property ($stable(gain_select_field) &&
		gain_select_field >= 3'h2 |-> buf_en) else $error("buffer off at high gain");
	a_busy_needs_osc: assert property (conv_busy |-> osc_on)
		else $error("conversion with oscillator off");
	a_wake_first: assert property ($rose(osc_on) |-> s_waking)
		else $error("conversion started without wake time");
	a_single_len: assert property ($fell(osc_on) |=> busy_len_r >= 2 * TADC_CYC - 32'd2)
		else $error("single conversion too short");
endmodule

bind adcseq_top adcseq_checker #(.TADC_CYC(TADC_CYC)) u_adcseq_checker (
	.core_clk(core_clk), .sys_rst(sys_rst), .cs_n(cs_n), .dout_oe(dout_oe),
	.osc_on(osc_on), .conv_busy(conv_busy), .buf_en(buf_en), .inamp_en(inamp_en),
	.gain_select_field(gain_select_field));

// *** tb/adcseq_host.sv ***
// Host serial master model: select, serial clock and data in frames.
// Assumes din is sampled on sclk rising edges, sclk idles high.
`timescale 1ns/1ns
module adcseq_host (
	// Clock
	input  wire core_clk,
	// Serial pins
	input  wire dout,
	input  wire dout_oe,
	output reg  sclk,
	output reg  cs_n,
	output reg  din
);
	reg  last_r;
	wire pin;

	// Released pin shows the inverse of the last driven level
	assign pin = dout_oe ? dout : ~last_r;

	initial begin
		last_r = 1'b0;
		sclk = 1'b1;
		cs_n = 1'b1;
		din = 1'b0;
	end

	always @(posedge core_clk) begin
		if (dout_oe === 1'b1)
			last_r <= dout;
	end

	// Half of a 64 ns serial period
	task half;
		begin
			repeat (8) @(posedge core_clk);
			#1;
		end
	endtask

	task sel(input v);
		begin
			@(posedge core_clk);
			#1;
			cs_n = v;
			half;
		end
	endtask

	// Shift n bits MSB first, sample the pin at each rising edge
	task xfer(input [31:0] tx, input integer n, output [31:0] rx);
		integer k;
		begin
			rx = 32'h0;
			@(posedge core_clk);
			#1;
			for (k = n - 1; k >= 0; k = k - 1) begin
				sclk = 1'b0;
				din = tx[k];
				half;
				rx = {rx[30:0], pin};
				sclk = 1'b1;
				half;
			end
			din = 1'b0;
		end
	endtask
endmodule

// *** tb/tb_top.sv ***
// Testbench for the converter mode sequencer: serial reads and writes
// through the host model; expected codes are worked out here.
`timescale 1ns/1ns
module tb_top;
	localparam DW   = 24;
	localparam WAKE = 200;
	localparam TADC = 2000;
	reg           core_clk;
	reg           sys_rst;
	reg  [DW-1:0] raw_sample;
	wire          sclk, cs_n, din, dout, dout_oe, osc_on, conv_busy;
	wire          buf_en, inamp_en, unipolar;
	wire [2:0]    gain_select_field;
	integer       errors, num_checks, i, c;
	reg  [31:0]   w;
	reg  [63:0]   tbl [0:4];

	adcseq_top #(.DW(DW), .OSC_WAKE_CYC(WAKE), .TADC_CYC(TADC)) u_adcseq_top (
		.core_clk(core_clk), .sys_rst(sys_rst), .sclk(sclk), .cs_n(cs_n), .din(din),
		.dout(dout), .dout_oe(dout_oe), .raw_sample(raw_sample), .osc_on(osc_on),
		.conv_busy(conv_busy), .buf_en(buf_en), .inamp_en(inamp_en),
		.gain_select_field(gain_select_field), .unipolar(unipolar));
	adcseq_host u_adcseq_host (.core_clk(core_clk), .dout(dout), .dout_oe(dout_oe),
		.sclk(sclk), .cs_n(cs_n), .din(din));

	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	// ----------------------------------------------------------
	// Compare, report and access tasks
	// ----------------------------------------------------------
	task chk(input string nm, input [31:0] exp, input [31:0] got);
		begin
			num_checks = num_checks + 1;
			if (got !== exp) begin
				errors = errors + 1;
				$display("ERROR %s expected %h seen %h", nm, exp, got);
			end
		end
	endtask
	task chk_rng(input string nm, input integer lo, input integer hi, input integer got);
		begin
			num_checks = num_checks + 1;
			if (got < lo || got > hi) begin
				errors = errors + 1;
				$display("ERROR %s expected %0d to %0d seen %0d", nm, lo, hi, got);
			end
		end
	endtask
	task stop_test;
		begin
			$display("Checks %0d errors %0d", num_checks, errors);
			if (errors == 0 && num_checks > 0)
				$display("Test passed");
			else
				$display("Test failed");
			$finish;
		end
	endtask
	task wait_rdy(output integer n);
		begin
			n = 0;
			while (!(dout_oe === 1'b1 && dout === 1'b0)) begin
				@(posedge core_clk);
				#1;
				n = n + 1;
				if (n > 3 * TADC) begin
					errors = errors + 1;
					$display("ERROR ready expected low seen high");
					stop_test;
				end
			end
		end
	endtask
	task cmd(input [7:0] b);
		u_adcseq_host.xfer({24'h0, b}, 8, w);
	endtask
	task wreg(input [7:0] b, input [15:0] v);
		begin
			cmd(b);
			u_adcseq_host.xfer({16'h0, v}, 16, w);
		end
	endtask
	task rd(input [7:0] b, input integer n, output [31:0] v);
		begin
			cmd(b);
			u_adcseq_host.xfer(32'h0, n, v);
		end
	endtask
	task getw(output [31:0] v);
		begin
			wait_rdy(c);
			rd(8'h58, 24, v);
		end
	endtask

	// ----------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------
	initial begin
		errors = 0;
		num_checks = 0;
		sys_rst = 1'b1;
		raw_sample = 24'h0;
		tbl[0] = 64'h0710_123456_923456;
		tbl[1] = 64'h0710_800000_000000;
		tbl[2] = 64'h1010_ffffff_ffffff;
		tbl[3] = 64'h1100_300000_600000;
		tbl[4] = 64'h1100_900000_ffffff;
		repeat (8) @(posedge core_clk);
		#1;
		sys_rst = 1'b0;
		u_adcseq_host.half;
		chk("oe idle", 32'h0, dout_oe);
		chk("gain reset", 32'h7, gain_select_field);
		chk("amp reset", 32'h1, inamp_en);
		chk("busy reset", 32'h1, conv_busy);
		u_adcseq_host.sel(1'b0);
		chk("oe select", 32'h1, dout_oe);
		rd(8'h40, 8, w);
		chk("status width", 32'h08, w & 32'h08);
		for (i = 0; i < 5; i = i + 1) begin
			wreg(8'h10, tbl[i][63:48]);
			raw_sample = tbl[i][47:24];
			getw(w);
			getw(w);
			chk("code", {8'h0, tbl[i][23:0]}, w);
			chk("polarity", tbl[i][60], unipolar);
		end
		rd(8'h58, 24, w);
		chk("reread", 32'hffffff, w);
		chk("ready after read", 32'h1, dout);
		rd(8'h40, 8, w);
		chk("status read flag", 32'h80, w & 32'h80);
		wait_rdy(c);
		rd(8'h40, 8, w);
		chk("status new flag", 32'h0, w & 32'h80);
		for (i = 0; i < 9; i = i + 1) begin
			wreg(8'h10, (i == 8) ? 16'h0010 : {5'h0, i[2:0], 8'h00});
			u_adcseq_host.half;
			chk("gain", i & 7, gain_select_field);
			chk("buffer", (i >= 2), buf_en);
			chk("amp", (i >= 2 && i < 8), inamp_en);
		end
		raw_sample = 24'h400000;
		getw(w);
		wreg(8'h08, 16'h2000);
		wait_rdy(c);
		chk_rng("single time", 2 * TADC - 16, 2 * TADC + 16, c);
		u_adcseq_host.half;
		chk("osc off", 32'h0, osc_on);
		rd(8'h58, 24, w);
		chk("single word", 32'hc00000, w);
		repeat (TADC) @(posedge core_clk);
		#1;
		chk("ready held", 32'h1, dout);
		wreg(8'h08, 16'h2000);
		wait_rdy(c);
		chk_rng("wake time", 2 * TADC + WAKE - 16, 2 * TADC + WAKE + 16, c);
		rd(8'h58, 24, w);
		raw_sample = 24'hff0000;
		wreg(8'h08, 16'h0000);
		cmd(8'h5c);
		wait_rdy(c);
		u_adcseq_host.xfer(32'h0, 24, w);
		chk("stream word", 32'h7f0000, w);
		u_adcseq_host.half;
		chk("stream idle", 32'h1, dout);
		raw_sample = 24'hff0001;
		wait_rdy(c);
		u_adcseq_host.xfer(32'h0, 8, w);
		repeat (TADC) @(posedge core_clk);
		#1;
		u_adcseq_host.xfer(32'h0, 24, w);
		chk("reloaded word", 32'h7f0001, w);
		wait_rdy(c);
		u_adcseq_host.xfer(32'h58, 8, w);
		u_adcseq_host.xfer(32'h0, 16, w);
		getw(w);
		chk("exit word", 32'h7f0001, w);
		cmd(8'h5c);
		u_adcseq_host.xfer(32'hffffffff, 32, w);
		u_adcseq_host.half;
		chk("ones reset", 32'h7, gain_select_field);
		chk("busy after ones", 32'h1, conv_busy);
		u_adcseq_host.sel(1'b1);
		chk("oe deselect", 32'h0, dout_oe);
		stop_test;
	end
endmodule
